// >>> rtl/irqpm_core.sv
// core side: takes orders over axi4-lite, drives the link
`timescale 1ns/1ps
`default_nettype none
`include "irqpm_map.svh"
module irqpm_core
   import irqpm_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // link to device
   irqpm_if.core lnk,
   // peripheral flag inputs (same clock)
   input wire logic [5:0] periph_flag,
   input wire logic t2_ovf_flag,
   input wire logic t2_pin_flag,
   input wire logic t2_updown,
   // axi4-lite slave
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic aw_ff, w_ff;
   logic [31:0] awaddr_ff, wdata_ff;
   logic wstb_ff;
   logic do_wr;
   logic [7:0] ctrl_ff;
   logic ack_ff;

   assign s_axi_awready = !aw_ff && !s_axi_bvalid;
   assign s_axi_wready = !w_ff && !s_axi_bvalid;
   assign do_wr = aw_ff && w_ff;

   // write address and data taken in either order
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         awaddr_ff <= 32'h0;
         wdata_ff <= 32'h0;
         wstb_ff <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstb_ff <= s_axi_wstrb[0];
         end
         if (do_wr) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_ff[31:2] == `IRQPM_REG_CTRL >> 2
               || awaddr_ff[31:2] == `IRQPM_REG_MASK >> 2) ? 2'h0 : 2'h2;
         end else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // control: bit0 idle request, bit1 power-down request, bit2 ack (pulses)
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         ctrl_ff <= 8'h00;
         ack_ff <= 1'b0;
      end else begin
         ctrl_ff <= 8'h00;
         ack_ff <= 1'b0;
         if (do_wr && wstb_ff && awaddr_ff[31:2] == `IRQPM_REG_CTRL >> 2) begin
            ctrl_ff <= wdata_ff[7:0];
            ack_ff <= wdata_ff[2];
         end
      end
   end

   assign lnk.mask_wr = do_wr && wstb_ff && awaddr_ff[31:2] == `IRQPM_REG_MASK >> 2;
   assign lnk.mask_wdata = wdata_ff[7:0] & `IRQPM_MASK_IMPL;
   assign lnk.idle_req = ctrl_ff[0];
   assign lnk.pd_req = ctrl_ff[1];
   assign lnk.irq_ack = ack_ff;
   assign lnk.raw_flag = periph_flag;
   assign lnk.timer2_overflow_flag = t2_ovf_flag;
   assign lnk.timer2_pin_event_flag = t2_pin_flag;
   assign lnk.t2_updown_mode = t2_updown;

   // read channel
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'h0;
         unique case (s_axi_araddr)
            `IRQPM_REG_CTRL: s_axi_rdata <= 32'h0;
            `IRQPM_REG_MASK: s_axi_rdata <= {24'h0, lnk.interrupt_enable_mask};
            `IRQPM_REG_STAT: s_axi_rdata <= {16'h0, 2'h0, lnk.port0_float,
               lnk.program_fetch_strobe_n, lnk.ale_level, lnk.ram_block, lnk.osc_run,
               lnk.cpu_halt, 1'b0, lnk.machine_state, lnk.irq_valid, lnk.irq_src};
            `IRQPM_REG_FLAG: s_axi_rdata <= {24'h0, 1'b0, lnk.t2_updown_mode,
               lnk.raw_flag};
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= 2'h2;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule
`default_nettype wire

// >>> rtl/irqpm_dev.sv
// interrupt enable gating and idle / power-down control
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "irqpm_map.svh"
module irqpm_dev
   import irqpm_pkg::*;
#(
   parameter int NSRC = `IRQPM_NSRC
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // link to core side
   irqpm_if.device lnk,
   // user side
   input wire logic ext_mem_exec,
   output logic in_idle,
   output logic in_pdown
);
   irqpm_mode_t mode_ff;
   logic [7:0] mask_ff;
   logic [2:0] st_ff;
   logic [2:0] nxt_st;
   logic [NSRC-1:0] req;
   logic [NSRC-1:0] poll_ff;
   logic [3:0] rstrun_ff;
   logic ext_meta_ff;
   logic ext_sync_ff;
   logic irq_any;
   logic [2:0] src_sel;

   // external-memory pin level through two flops
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         ext_meta_ff <= 1'b0;
         ext_sync_ff <= 1'b0;
      end else begin
         ext_meta_ff <= ext_mem_exec;
         ext_sync_ff <= ext_meta_ff;
      end
   end

   // machine cycle state counter s1..s6
   assign nxt_st = (st_ff == 3'(`IRQPM_STATES - 1)) ? 3'h0 : st_ff + 3'h1;
   always_ff @(posedge clk_sys) begin
      if (!reset_n)
         st_ff <= 3'h0;
      else if (mode_ff != PM_DOWN)
         st_ff <= nxt_st;
   end

   // enable mask, reserved bit forced to zero
   always_ff @(posedge clk_sys) begin
      if (!reset_n)
         mask_ff <= `IRQPM_MASK_RST;
      else if (lnk.mask_wr && mode_ff == PM_RUN)
         mask_ff <= lnk.mask_wdata & `IRQPM_MASK_IMPL;
   end

   // per-source request, timer 2 is overflow OR pin flag outside up/down mode
   genvar gr;
   generate
      for (gr = 0; gr < NSRC; gr++) begin : g_req
         if (gr == `IRQPM_BIT_ET2) begin : g_t2
            assign req[gr] = lnk.timer2_overflow_flag
               | (lnk.timer2_pin_event_flag & ~lnk.t2_updown_mode);
         end else begin : g_raw
            assign req[gr] = lnk.raw_flag[gr];
         end
      end
   endgenerate

   // sampling: timer 0/1 at state5_phase2 then polled next cycle, timer 2 at state2_phase2 same cycle
   genvar gi;
   generate
      for (gi = 0; gi < NSRC; gi++) begin : g_poll
         if (gi == `IRQPM_BIT_ET2) begin : g_t2
            // held while overflow, or pin flag outside up/down mode, stays set, software clears them
            always_ff @(posedge clk_sys) begin
               if (!reset_n)
                  poll_ff[gi] <= 1'b0;
               else if (st_ff == 3'h1)
                  poll_ff[gi] <= req[gi];
               else
                  poll_ff[gi] <= poll_ff[gi] & req[gi];
            end
         end else begin : g_other
            // latched once per machine cycle with its enable
            always_ff @(posedge clk_sys) begin
               if (!reset_n)
                  poll_ff[gi] <= 1'b0;
               else if (st_ff == 3'h5)
                  poll_ff[gi] <= req[gi] & mask_ff[gi];
            end
         end
      end
   endgenerate

   // enables and global gate; flags themselves are never cleared here
   always_comb begin
      irq_any = 1'b0;
      src_sel = 3'h0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (poll_ff[i] && mask_ff[i] && mask_ff[`IRQPM_BIT_EA]) begin
            irq_any = 1'b1;
            src_sel = 3'(i);
         end
      end
   end
   assign lnk.irq_valid = irq_any && mode_ff != PM_DOWN;
   assign lnk.irq_src = src_sel;

   // power mode machine
   always_ff @(posedge clk_sys) begin
      if (!reset_n)
         mode_ff <= PM_RUN;
      else begin
         unique case (mode_ff)
            PM_RUN: begin
               if (lnk.pd_req)
                  mode_ff <= PM_DOWN;
               else if (lnk.idle_req)
                  mode_ff <= PM_IDLE;
            end
            PM_IDLE: begin
               if (irq_any)
                  mode_ff <= PM_RUN;
            end
            PM_DOWN: begin
               mode_ff <= PM_DOWN;
            end
         endcase
      end
   end

   // window after reset leaves idle: cpu runs briefly, ram blocked
   always_ff @(posedge clk_sys) begin
      if (!reset_n && mode_ff == PM_IDLE)
         rstrun_ff <= 4'(`IRQPM_RST_RUN_CYC * `IRQPM_STATES);
      else if (rstrun_ff != 4'h0)
         rstrun_ff <= rstrun_ff - 4'h1;
      else if (!reset_n)
         rstrun_ff <= 4'h0;
   end

   assign lnk.ram_block = rstrun_ff != 4'h0
      || (mode_ff == PM_IDLE && !reset_n);
   assign lnk.cpu_halt = mode_ff != PM_RUN;
   assign lnk.osc_run = mode_ff != PM_DOWN;
   assign lnk.interrupt_enable_mask = mask_ff;
   assign lnk.machine_state = st_ff;
   assign lnk.mode = mode_ff;
   assign lnk.ale_level = mode_ff == PM_IDLE;
   assign lnk.program_fetch_strobe_n = mode_ff == PM_IDLE;
   assign lnk.port0_float = ext_sync_ff && mode_ff != PM_RUN;
   assign in_idle = mode_ff == PM_IDLE;
   assign in_pdown = mode_ff == PM_DOWN;
endmodule
`default_nettype wire

// >>> rtl/irqpm_if.sv
// link between the interrupt block and the core/peripheral side
`timescale 1ns/1ps
`default_nettype none
interface irqpm_if;
   import irqpm_pkg::*;
   // peripheral flag sources
   logic [5:0] raw_flag;
   logic timer2_overflow_flag;
   logic timer2_pin_event_flag;
   logic t2_updown_mode;
   // cpu core sequencer
   logic mask_wr;
   logic [7:0] mask_wdata;
   logic [7:0] interrupt_enable_mask;
   logic idle_req;
   logic pd_req;
   logic irq_valid;
   logic [2:0] irq_src;
   logic irq_ack;
   logic cpu_halt;
   logic osc_run;
   logic ram_block;
   logic [2:0] machine_state;
   logic [1:0] mode;
   logic ale_level;
   logic program_fetch_strobe_n;
   logic port0_float;
   modport device (
      input raw_flag, timer2_overflow_flag, timer2_pin_event_flag, t2_updown_mode,
      input mask_wr, mask_wdata, idle_req, pd_req, irq_ack,
      output interrupt_enable_mask, irq_valid, irq_src, cpu_halt, osc_run, ram_block,
      output machine_state, mode, ale_level, program_fetch_strobe_n, port0_float
   );
   modport core (
      output raw_flag, timer2_overflow_flag, timer2_pin_event_flag, t2_updown_mode,
      output mask_wr, mask_wdata, idle_req, pd_req, irq_ack,
      input interrupt_enable_mask, irq_valid, irq_src, cpu_halt, osc_run, ram_block,
      input machine_state, mode, ale_level, program_fetch_strobe_n, port0_float
   );
endinterface
`default_nettype wire

// >>> rtl/irqpm_map.svh
// constants for the interrupt enable and power mode block
// Function
// - six sources: two pins, three timers, serial
// - per-source enable bit, 1 allows, 0 blocks
// - global enable bit 7 gates all requests
// - mask bits: t2=5 ser=4 t1=3 x1=2 t0=1 x0=0
// - software never writes 1 to reserved bits
// - timer 2 request is overflow OR pin event
// - timer 2 flags cleared only by software
// - timer 0/1 flags set state5_phase2, polled next cycle
// - timer 2 flag set state2_phase2, polled same cycle
// - idle halts cpu, peripherals keep running
// - idle keeps ram and register contents
// - idle ends on enabled request or reset
// - reset from idle: cpu may run two cycles
// - in that window block ram, not ports
// - no port write right after idle entry
// - power-down stops oscillator after last instruction
// - power-down keeps state, exits only by reset
// - reset from power-down reinits registers, keeps ram
// - reset held until oscillator stable
// - strobes 1 in idle, 0 in power-down, port0 floats; here only while ext_mem_exec is high
// - up/down reload mode pin event raises no request
`ifndef IRQPM_MAP_SVH
`define IRQPM_MAP_SVH
`define IRQPM_BIT_EX0 0
`define IRQPM_BIT_ET0 1
`define IRQPM_BIT_EX1 2
`define IRQPM_BIT_ET1 3
`define IRQPM_BIT_ES 4
`define IRQPM_BIT_ET2 5
`define IRQPM_BIT_RSV 6
`define IRQPM_BIT_EA 7
`define IRQPM_MASK_RST 8'h00
`define IRQPM_MASK_IMPL 8'hbf
`define IRQPM_NSRC 6
`define IRQPM_STATES 6
`define IRQPM_RST_RUN_CYC 2
`define IRQPM_REG_CTRL 32'h0000_0000
`define IRQPM_REG_MASK 32'h0000_0004
`define IRQPM_REG_STAT 32'h0000_0008
`define IRQPM_REG_FLAG 32'h0000_000c
`endif

// >>> rtl/irqpm_pkg.sv
// types for the interrupt enable and power mode block
package irqpm_pkg;
   typedef enum logic [1:0] {
      PM_RUN,
      PM_IDLE,
      PM_DOWN
   } irqpm_mode_t;
   typedef logic [2:0] irqpm_src_t;
endpackage

// >>> verification/irqpm_properties.sv
// concurrent checks on the link between the interrupt block and the core side
`timescale 1ns/1ps
`default_nettype none
module irqpm_properties
   import irqpm_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // link signals
   input wire logic [7:0] interrupt_enable_mask,
   input wire logic mask_wr,
   input wire logic [7:0] mask_wdata,
   input wire logic pd_req,
   input wire logic irq_valid,
   input wire logic [2:0] irq_src,
   input wire logic cpu_halt,
   input wire logic osc_run,
   input wire logic [1:0] mode,
   input wire logic ale_level,
   input wire logic program_fetch_strobe_n,
   input wire logic ram_block
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   a_global_gate: assert property (!interrupt_enable_mask[7] |-> !irq_valid)
      else $error("request seen with global enable clear");
   a_src_enabled: assert property (irq_valid |-> interrupt_enable_mask[irq_src])
      else $error("request from a disabled source");
   a_src_range: assert property (irq_valid |-> irq_src < 3'h6)
      else $error("request source index out of range");
   a_mask_write: assert property (mask_wr && mode == PM_RUN |=>
      interrupt_enable_mask == ($past(mask_wdata) & 8'hbf))
      else $error("mask not loaded with written value");
   a_mask_hold: assert property (!mask_wr |=> $stable(interrupt_enable_mask))
      else $error("mask changed without a write");
   a_idle_outputs: assert property (mode == PM_IDLE |->
      cpu_halt && ale_level && program_fetch_strobe_n)
      else $error("idle outputs wrong");
   a_down_outputs: assert property (mode == PM_DOWN |->
      !osc_run && !ale_level && !program_fetch_strobe_n)
      else $error("power-down outputs wrong");
   a_down_sticky: assert property (mode == PM_DOWN |=> mode == PM_DOWN)
      else $error("power-down left without reset");
   a_idle_wakes: assert property (mode == PM_IDLE && irq_valid |->
      ##[1:6] mode == PM_RUN)
      else $error("idle not ended by enabled request");
   a_ram_window: assert property (disable iff (1'b0)
      $fell(reset_n) && mode == PM_IDLE |=> ram_block [*8])
      else $error("ram not blocked after reset from idle");
   a_down_enter: assert property (pd_req && mode == PM_RUN |-> ##[1:2] mode == PM_DOWN)
      else $error("power-down not entered");
   c_wake: cover property (mode == PM_IDLE ##1 mode == PM_RUN);
   c_down: cover property (mode == PM_DOWN);
   c_t2_irq: cover property (irq_valid && irq_src == 3'h5);
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench for the interrupt block and core side pair
`timescale 1ns/1ps
`default_nettype none
`include "irqpm_map.svh"
module testbench;
   import irqpm_pkg::*;
   logic clk_sys = 0, reset_n = 0, ext_mem_exec = 0, t2_ovf_flag = 0, t2_pin_flag = 0;
   logic t2_updown = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, in_idle, in_pdown;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [5:0] periph_flag = 0;
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [7:0] m;
   int errors = 0, n_checks = 0;
   always #10 clk_sys = ~clk_sys;
   irqpm_if lnk ();
   irqpm_dev i_irqpm_dev (.clk_sys(clk_sys), .reset_n(reset_n), .lnk(lnk),
      .ext_mem_exec(ext_mem_exec), .in_idle(in_idle), .in_pdown(in_pdown));
   irqpm_core i_irqpm_core (.clk_sys(clk_sys), .reset_n(reset_n), .lnk(lnk),
      .periph_flag(periph_flag), .t2_ovf_flag(t2_ovf_flag), .t2_pin_flag(t2_pin_flag),
      .t2_updown(t2_updown), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   irqpm_properties i_irqpm_properties (.clk_sys(clk_sys), .reset_n(reset_n),
      .interrupt_enable_mask(lnk.interrupt_enable_mask), .mask_wr(lnk.mask_wr),
      .mask_wdata(lnk.mask_wdata), .pd_req(lnk.pd_req), .irq_valid(lnk.irq_valid),
      .irq_src(lnk.irq_src), .cpu_halt(lnk.cpu_halt), .osc_run(lnk.osc_run), .mode(lnk.mode),
      .ale_level(lnk.ale_level), .program_fetch_strobe_n(lnk.program_fetch_strobe_n),
      .ram_block(lnk.ram_block));
   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      bit aw, w, b;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(negedge clk_sys);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge clk_sys);
         if (aw) s_axi_awvalid <= 0;
         if (w) s_axi_wvalid <= 0;
      end while (!b);
      s_axi_bready <= 0;
   endtask
   task automatic rd(input logic [31:0] a);
      bit ar, b;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(negedge clk_sys);
         ar = s_axi_arvalid && s_axi_arready;
         b = s_axi_rvalid;
         d = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge clk_sys);
         if (ar) s_axi_arvalid <= 0;
      end while (!b);
      s_axi_rready <= 0;
   endtask
   function automatic logic [31:0] exp_irq(input logic [7:0] k);
      logic [5:0] p;
      p = {t2_ovf_flag | (t2_pin_flag & ~t2_updown), periph_flag[4:0]} & k[5:0];
      exp_irq = 0;
      for (int i = 5; i >= 0; i--) begin
         if (k[7] && p[i]) exp_irq = 32'(8 + i);
      end
   endfunction
   task automatic wait_poll;
      repeat (14) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'h398fb805));
      repeat (16) @(posedge clk_sys);
      reset_n <= 1;
      rd(`IRQPM_REG_MASK);
      chk("mask reset", 0, d);
      wr(32'h10, 1);
      chk("unmapped bresp", 2, 32'(rs));
      rd(32'h10);
      chk("unmapped rresp", 2, 32'(rs));
      chk("unmapped rdata", 0, d);
      $display("test reset_and_map done");
      repeat (12) begin
         m = 8'($urandom) & 8'hbf;
         wr(`IRQPM_REG_MASK, 32'(m));
         rd(`IRQPM_REG_MASK);
         chk("mask", 32'(m), d);
         @(posedge clk_sys);
         {periph_flag, t2_ovf_flag, t2_pin_flag, t2_updown} <= 9'($urandom);
         wait_poll();
         rd(`IRQPM_REG_STAT);
         chk("irq", exp_irq(m), d[3] ? 32'(d[3:0]) : 32'h0);
      end
      $display("test gating done");
      @(posedge clk_sys);
      {periph_flag, t2_ovf_flag, t2_pin_flag} <= 8'h00;
      ext_mem_exec <= 1'($urandom);
      wr(`IRQPM_REG_MASK, 32'h81);
      wr(`IRQPM_REG_CTRL, 1);
      wr(`IRQPM_REG_MASK, 0);
      rd(`IRQPM_REG_MASK);
      chk("mask in idle", 32'h81, d);
      rd(`IRQPM_REG_STAT);
      chk("idle pins", 32'({ext_mem_exec, 5'h1b}), 32'(d[13:8]));
      @(negedge clk_sys);
      chk("in idle", 1, 32'(in_idle));
      @(posedge clk_sys);
      periph_flag[0] <= 1;
      wait_poll();
      chk("idle woken", 0, 32'(in_idle));
      $display("test idle done");
      @(posedge clk_sys);
      periph_flag[0] <= 0;
      wr(`IRQPM_REG_CTRL, 2);
      rd(`IRQPM_REG_STAT);
      chk("down pins", 32'({ext_mem_exec, 5'h01}), 32'(d[13:8]));
      @(posedge clk_sys);
      periph_flag[0] <= 1;
      wait_poll();
      chk("still down", 1, 32'(in_pdown));
      @(posedge clk_sys);
      reset_n <= 0;
      repeat (16) @(posedge clk_sys);
      reset_n <= 1;
      @(negedge clk_sys);
      chk("down after reset", 0, 32'(in_pdown));
      rd(`IRQPM_REG_MASK);
      chk("mask after reset", 0, d);
      $display("test power_down done");
      wr(`IRQPM_REG_CTRL, 1);
      @(posedge clk_sys);
      reset_n <= 0;
      repeat (16) @(posedge clk_sys);
      reset_n <= 1;
      @(negedge clk_sys);
      chk("idle after reset", 0, 32'(in_idle));
      rd(`IRQPM_REG_STAT);
      chk("ram window closed", 0, 32'(d[10]));
      $display("test idle_reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
